// *** common/m2pd_params.svh ***
// Offsets, field positions, reset values and widths of the DMA channel buffer and status block.
`ifndef M2PD_PARAMS_SVH
`define M2PD_PARAMS_SVH

`define M2PD_ADDR_W          8
`define M2PD_CNT_W           16
`define M2PD_FILL_W          3

`define M2PD_OFF_CTRL        8'h00
`define M2PD_OFF_STATUS      8'h0c
`define M2PD_OFF_LEFT        8'h14
`define M2PD_OFF_LIM0        8'h20
`define M2PD_OFF_BUFFER0_START_ADDR       8'h24
`define M2PD_OFF_LIVE0       8'h28
`define M2PD_OFF_LIM1        8'h30
`define M2PD_OFF_BUFFER1_START_ADDR       8'h34
`define M2PD_OFF_LIVE1       8'h38

`define M2PD_CTRL_EN         0
`define M2PD_CTRL_HALT_IE    1
`define M2PD_CTRL_REFILL_IE  2
`define M2PD_CTRL_HALT_FAULT 3
`define M2PD_CTRL_FAULT_IGN  4
`define M2PD_CTRL_DIR_RX     5
`define M2PD_CTRL_W          6
`define M2PD_CTRL_RST        6'h00

`define M2PD_ST_STALL        0
`define M2PD_ST_REQ          1
`define M2PD_ST_FAULT        3
`define M2PD_ST_STATE_LO     4
`define M2PD_ST_SEL          6
`define M2PD_ST_FILL_LO      7

`define M2PD_MEM_LIM0        2'h0
`define M2PD_MEM_BUFFER0_START_ADDR       2'h1
`define M2PD_MEM_LIM1        2'h2
`define M2PD_MEM_BUFFER1_START_ADDR       2'h3

`endif

// *** common/m2pd_pkg.sv ***
// Types and shared functions of the DMA channel buffer and status block.
package m2pd_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STALL,
    ST_ON,
    ST_NEXT
  } m2pd_state_e;

  function automatic logic [1:0] state_code(input m2pd_state_e st);
    case (st)
      ST_IDLE:  state_code = 2'h0;
      ST_STALL: state_code = 2'h1;
      ST_ON:    state_code = 2'h2;
      ST_NEXT:  state_code = 2'h3;
      default:  state_code = 2'h0;
    endcase
  endfunction

endpackage

// *** src/m2pd_channel.sv ***
// Buffer descriptor, bytes-left and status logic of one memory-to-peripheral DMA channel.
// Functional notes
// - Stall status bit reads 1 while the channel waits for a start address after a buffer ended in on.
// - Entering stall from idle raises neither stall flag nor stall event.
// - A start-address write or disable leaves the stall state.
// - Zero count at stop means done; nonzero means peripheral ended; error sets fault.
// - Descriptor request bit sets when the machine moves from next to on.
// - Request bit set means the idle pair may be rewritten; event raised if enabled.
// - Fault flag is 0 after clean completion, 1 after error termination.
// - Status shows the fill count of the packer or unpacker.
// - State field codes idle 00, stall 01, on 10, next 11.
// - Selector goes 1 on first start-address write, 0 on the second.
// - Running buffer continues until it ends, then switches and raises request event.
// - Active buffer follows from state and selector as the table says.
// - Each entry into on loads the counter from the chosen byte limit.
// - Counter drops by one per byte moved.
// - Counter reaching zero completes the buffer and pulses terminal count.
// - Peripheral end stops early and the nonzero count is kept.
// - Count and byte limits hold 16 bits; the upper bits are reserved.
// - Enable moves to stall; a later start-address write moves to on.
// - A start-address write loads the live pointer and makes that buffer active; the code skips the load for the running buffer and while disabled.
// - Live pointer keeps the post-incremented address when the buffer ends.
// - Stall event on on-to-stall only while the halt event enable is set.
// - Request event on next-to-on only while the refill event enable is set.
// - Disabling the channel flushes the packer or unpacker.
// - Error in next: halt-on-fault picks on or silent stall; fault-ignore overrides.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "m2pd_params.svh"

module m2pd_channel (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    pclken,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`M2PD_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    byte_moved,
  input  wire logic                    tx_early_stop,
  input  wire logic                    rx_early_stop,
  input  wire logic                    stop_error,
  input  wire logic [`M2PD_FILL_W-1:0] pack_fill,
  output logic                         xfer_active,
  output logic                         active_buf,
  output logic      [31:0]             active_addr,
  output logic                         tx_count_done,
  output logic                         rx_count_done,
  output logic                         pack_flush,
  output logic                         halt_irq,
  output logic                         refill_irq
);

  m2pd_pkg::m2pd_state_e       state_ff;
  m2pd_pkg::m2pd_state_e       nxt_state;
  logic [`M2PD_CTRL_W-1:0]     ctrl_ff;
  logic                        active_ff;
  logic                        nxt_active;
  logic                        sel_ff;
  logic                        stall_flag_ff;
  logic                        req_flag_ff;
  logic                        fault_flag_ff;
  logic [31:0]                 live_ff [2];
  logic [31:0]                 prdata_ff;
  logic                        rd_mem_ff;
  logic [31:0]                 mem_rdata;
  logic [15:0]                 lim0;
  logic [15:0]                 lim1;
  logic [`M2PD_CNT_W-1:0]      left_count_reg;
  logic                        left_last;
  logic                        enter_on;
  logic                        stall_set;
  logic                        req_set;
  logic                        en;
  logic                        wr;
  logic                        setup;
  logic                        base_wr0;
  logic                        base_wr1;
  logic                        base_any;
  logic                        byte_ok;
  logic                        end_count;
  logic                        early;
  logic                        err_stop;
  logic                        fault_term;
  logic                        buf_end;
  logic                        mem_hit;
  logic [1:0]                  mem_idx;

  // Maps a bus offset onto the descriptor store; the second bit is the buffer number.
  function automatic logic mem_map(input logic [`M2PD_ADDR_W-1:0] a, output logic [1:0] idx);
    mem_map = 1'b1;
    case (a)
      `M2PD_OFF_LIM0:  idx = `M2PD_MEM_LIM0;
      `M2PD_OFF_BUFFER0_START_ADDR: idx = `M2PD_MEM_BUFFER0_START_ADDR;
      `M2PD_OFF_LIM1:  idx = `M2PD_MEM_LIM1;
      `M2PD_OFF_BUFFER1_START_ADDR: idx = `M2PD_MEM_BUFFER1_START_ADDR;
      default: begin
        idx     = 2'h0;
        mem_map = 1'b0;
      end
    endcase
  endfunction

  function automatic logic is_mapped(input logic [`M2PD_ADDR_W-1:0] a);
    case (a)
      `M2PD_OFF_CTRL, `M2PD_OFF_STATUS, `M2PD_OFF_LEFT, `M2PD_OFF_LIM0, `M2PD_OFF_BUFFER0_START_ADDR,
      `M2PD_OFF_LIVE0, `M2PD_OFF_LIM1, `M2PD_OFF_BUFFER1_START_ADDR, `M2PD_OFF_LIVE1: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // The slave answers in the first access cycle; a frozen clock enable holds the answer off.
  assign pready   = pclken;
  assign pslverr  = psel && penable && !is_mapped(paddr);
  assign setup    = pclken && psel && !penable;
  assign wr       = pclken && psel && penable && pwrite && is_mapped(paddr);
  assign base_wr0 = wr && (paddr == `M2PD_OFF_BUFFER0_START_ADDR);
  assign base_wr1 = wr && (paddr == `M2PD_OFF_BUFFER1_START_ADDR);
  assign base_any = base_wr0 || base_wr1;
  // A function with an output argument may not drive a continuous assignment.
  always_comb begin
    mem_hit = mem_map(paddr, mem_idx);
  end
  assign en       = ctrl_ff[`M2PD_CTRL_EN];

  assign xfer_active = (state_ff == m2pd_pkg::ST_ON) || (state_ff == m2pd_pkg::ST_NEXT);
  assign byte_ok     = byte_moved && xfer_active;
  assign end_count   = byte_ok && left_last;
  assign early       = (tx_early_stop || rx_early_stop) && xfer_active;
  assign err_stop    = early && stop_error;
  // An error while faults are ignored neither ends the buffer nor marks it.
  assign fault_term  = err_stop && !ctrl_ff[`M2PD_CTRL_FAULT_IGN];
  assign buf_end     = end_count || (early && !(err_stop && ctrl_ff[`M2PD_CTRL_FAULT_IGN]));

  m2pd_desc_mem u_desc_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .pclken  (pclken),
    .wr_en   (wr && mem_hit),
    .wr_idx  (mem_idx),
    .wr_data (pwdata),
    .rd_en   (setup && mem_hit),
    .rd_idx  (mem_idx),
    .rd_data (mem_rdata),
    .lim0    (lim0),
    .lim1    (lim1)
  );

  m2pd_left_counter u_left_counter (
    .pclk     (pclk),
    .presetn  (presetn),
    .pclken   (pclken),
    .load     (enter_on),
    .load_val (nxt_active ? lim1 : lim0),
    .dec      (byte_ok),
    .count    (left_count_reg),
    .last     (left_last)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `M2PD_CTRL_RST;
    end else if (pclken && wr && paddr == `M2PD_OFF_CTRL) begin
      ctrl_ff <= pwdata[`M2PD_CTRL_W-1:0];
    end
  end

  // Channel state machine. Disable overrides every other cause.
  always_comb begin
    nxt_state  = state_ff;
    nxt_active = active_ff;
    enter_on   = 1'b0;
    stall_set  = 1'b0;
    req_set    = 1'b0;
    case (state_ff)
      m2pd_pkg::ST_IDLE: begin
        if (en) begin
          nxt_state = m2pd_pkg::ST_STALL;
        end
      end
      m2pd_pkg::ST_STALL: begin
        if (base_any) begin
          nxt_state  = m2pd_pkg::ST_ON;
          nxt_active = base_wr1;
          enter_on   = 1'b1;
        end
      end
      m2pd_pkg::ST_ON: begin
        if (buf_end && base_any) begin
          nxt_active = base_wr1;
          enter_on   = 1'b1;
          req_set    = 1'b1;
        end else if (buf_end) begin
          nxt_state = m2pd_pkg::ST_STALL;
          stall_set = 1'b1;
        end else if (base_any) begin
          nxt_state = m2pd_pkg::ST_NEXT;
        end
      end
      m2pd_pkg::ST_NEXT: begin
        if (buf_end && fault_term && ctrl_ff[`M2PD_CTRL_HALT_FAULT]) begin
          nxt_state = m2pd_pkg::ST_STALL;
        end else if (buf_end) begin
          nxt_state  = m2pd_pkg::ST_ON;
          nxt_active = !active_ff;
          enter_on   = 1'b1;
          req_set    = 1'b1;
        end
      end
      default: nxt_state = m2pd_pkg::ST_IDLE;
    endcase
    if (!en) begin
      nxt_state  = m2pd_pkg::ST_IDLE;
      nxt_active = 1'b0;
      enter_on   = 1'b0;
      stall_set  = 1'b0;
      req_set    = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff  <= m2pd_pkg::ST_IDLE;
      active_ff <= 1'b0;
    end else if (pclken) begin
      state_ff  <= nxt_state;
      active_ff <= nxt_active;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ff <= 1'b0;
    end else if (pclken) begin
      if (base_wr0) begin
        sel_ff <= 1'b1;
      end else if (base_wr1) begin
        sel_ff <= 1'b0;
      end
    end
  end

  // A write to the running buffer's start address does not load its live pointer, so the pointer
  // in flight is not disturbed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_ff[0] <= 32'h0000_0000;
      live_ff[1] <= 32'h0000_0000;
    end else if (pclken) begin
      for (int b = 0; b < 2; b++) begin
        if ((b == 0 ? base_wr0 : base_wr1) && en && !(xfer_active && active_ff == b[0])) begin
          live_ff[b] <= pwdata;
        end else if (byte_ok && active_ff == b[0]) begin
          live_ff[b] <= live_ff[b] + 32'h0000_0001;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_flag_ff <= 1'b0;
    end else if (pclken) begin
      if (stall_set) begin
        stall_flag_ff <= 1'b1;
      end else if (!en || base_any) begin
        stall_flag_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_flag_ff <= 1'b0;
    end else if (pclken) begin
      if (req_set) begin
        req_flag_ff <= 1'b1;
      end else if (!en || nxt_state != m2pd_pkg::ST_ON) begin
        req_flag_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_flag_ff <= 1'b0;
    end else if (pclken) begin
      if (!en) begin
        fault_flag_ff <= 1'b0;
      end else if (buf_end) begin
        fault_flag_ff <= fault_term;
      end
    end
  end

  // Events go out as single-cycle pulses; counting them is left to the interrupt controller.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_irq   <= 1'b0;
      refill_irq <= 1'b0;
    end else if (pclken) begin
      halt_irq   <= stall_set && ctrl_ff[`M2PD_CTRL_HALT_IE];
      refill_irq <= req_set && ctrl_ff[`M2PD_CTRL_REFILL_IE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_count_done <= 1'b0;
      rx_count_done <= 1'b0;
    end else if (pclken) begin
      tx_count_done <= end_count && !ctrl_ff[`M2PD_CTRL_DIR_RX];
      rx_count_done <= end_count && ctrl_ff[`M2PD_CTRL_DIR_RX];
    end
  end

  assign pack_flush  = !en;
  assign active_buf  = active_ff;
  assign active_addr = live_ff[active_ff];

  // Read data are captured in the setup cycle so the access cycle can answer at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      rd_mem_ff <= 1'b0;
    end else if (setup) begin
      rd_mem_ff <= mem_hit;
      case (paddr)
        `M2PD_OFF_CTRL:   prdata_ff <= {26'h0, ctrl_ff};
        `M2PD_OFF_STATUS: prdata_ff <= {22'h0, pack_fill,
                                        sel_ff,
                                        m2pd_pkg::state_code(state_ff),
                                        fault_flag_ff, 1'b0,
                                        req_flag_ff, stall_flag_ff};
        `M2PD_OFF_LEFT:   prdata_ff <= {16'h0000, left_count_reg};
        `M2PD_OFF_LIVE0:  prdata_ff <= live_ff[0];
        `M2PD_OFF_LIVE1:  prdata_ff <= live_ff[1];
        default:          prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = rd_mem_ff ? mem_rdata : prdata_ff;

  AST_STALL_ONLY_IN_STALL: assert property (@(posedge pclk) disable iff (!presetn)
    stall_flag_ff |-> state_ff == m2pd_pkg::ST_STALL)
    else $error("stall flag set outside the stall state");

  AST_NO_STALL_FROM_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    (pclken && en && state_ff == m2pd_pkg::ST_IDLE) |=> (state_ff == m2pd_pkg::ST_STALL && !stall_flag_ff && !halt_irq))
    else $error("stall indicated on entry from idle");

  AST_BASE_LEAVES_STALL: assert property (@(posedge pclk) disable iff (!presetn)
    (pclken && en && state_ff == m2pd_pkg::ST_STALL && base_any) |=> (state_ff == m2pd_pkg::ST_ON && !stall_flag_ff))
    else $error("start address write did not leave stall");

  AST_REQ_ON_NEXT_TO_ON: assert property (@(posedge pclk) disable iff (!presetn)
    (pclken && state_ff == m2pd_pkg::ST_NEXT && nxt_state == m2pd_pkg::ST_ON)
    |=> (req_flag_ff && active_ff != $past(active_ff)))
    else $error("request flag or buffer switch missing");

  AST_SEL_FOLLOWS_BASE: assert property (@(posedge pclk) disable iff (!presetn)
    (base_wr0 || base_wr1) |=> (sel_ff == $past(base_wr0)))
    else $error("free descriptor selector wrong after start address write");

  AST_LOAD_ON_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
    (pclken && enter_on) |=> (left_count_reg == (active_ff ? lim1 : lim0)))
    else $error("bytes-left not loaded on entry into on");

  AST_COUNT_DOWN: assert property (@(posedge pclk) disable iff (!presetn)
    (pclken && byte_ok && !enter_on && left_count_reg != 16'h0000)
    |=> (left_count_reg == $past(left_count_reg) - 16'h0001))
    else $error("bytes-left did not drop by one");

  AST_TC_AT_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (pclken && end_count && !enter_on) |=> ((tx_count_done || rx_count_done) && left_count_reg == 16'h0000))
    else $error("terminal count missing at zero");

  AST_DISABLE_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    (pclken && !en) |=> (state_ff == m2pd_pkg::ST_IDLE && !stall_flag_ff && !req_flag_ff && !fault_flag_ff))
    else $error("disable did not return to a clean idle");

endmodule // m2pd_channel

// *** src/m2pd_desc_mem.sv ***
// Descriptor store: two byte limits and two start addresses, registered read port.
`timescale 1ns/100ps
`include "m2pd_params.svh"

module m2pd_desc_mem (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pclken,
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_idx,
  input  wire logic [31:0] wr_data,
  input  wire logic        rd_en,
  input  wire logic [1:0]  rd_idx,
  output logic      [31:0] rd_data,
  output logic      [15:0] lim0,
  output logic      [15:0] lim1
);

  logic [31:0] mem_ff [4];

  // Limits keep only their low half so the upper bits read back as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        mem_ff[i] <= 32'h0000_0000;
      end
    end else if (pclken && wr_en) begin
      if (wr_idx[0]) begin
        mem_ff[wr_idx] <= wr_data;
      end else begin
        mem_ff[wr_idx] <= {16'h0000, wr_data[15:0]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= 32'h0000_0000;
    end else if (pclken && rd_en) begin
      rd_data <= mem_ff[rd_idx];
    end
  end

  assign lim0 = mem_ff[`M2PD_MEM_LIM0][15:0];
  assign lim1 = mem_ff[`M2PD_MEM_LIM1][15:0];

endmodule // m2pd_desc_mem

// *** src/m2pd_left_counter.sv ***
// Bytes-left down counter with load and one-before-zero detect.
`timescale 1ns/100ps
`include "m2pd_params.svh"

module m2pd_left_counter (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   pclken,
  input  wire logic                   load,
  input  wire logic [`M2PD_CNT_W-1:0] load_val,
  input  wire logic                   dec,
  output logic      [`M2PD_CNT_W-1:0] count,
  output logic                        last
);

  // Load wins over a decrement in the same cycle, since a new buffer starts afresh.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
    end else if (pclken) begin
      if (load) begin
        count <= load_val;
      end else if (dec && count != 16'h0000) begin
        count <= count - 16'h0001;
      end
    end
  end

  assign last = (count == 16'h0001);

endmodule // m2pd_left_counter

// *** test/m2pd_periph_model.sv ***
// Peripheral FIFO model on the transfer side of the channel.
`timescale 1ns/100ps

module m2pd_periph_model (
  input  wire logic       pclk,
  input  wire logic       xfer_active,
  output logic            byte_moved,
  output logic            tx_early_stop,
  output logic            rx_early_stop,
  output logic            stop_error,
  output logic      [2:0] pack_fill
);
  initial begin
    {byte_moved, tx_early_stop, rx_early_stop, stop_error, pack_fill} = '0;
  end

  // Random gaps between bytes make the peripheral both prompt and slow.
  task automatic send(input int n, input logic stp, input logic err, input logic rx);
    pack_fill <= 3'($urandom);
    repeat (n) begin
      @(posedge pclk);
      byte_moved <= 1'b1;
      if ($urandom % 2) begin
        @(posedge pclk);
        byte_moved <= 1'b0;
      end
    end
    @(posedge pclk);
    byte_moved    <= 1'b0;
    tx_early_stop <= stp & !rx & xfer_active;
    rx_early_stop <= stp & rx & xfer_active;
    stop_error    <= err;
    @(posedge pclk);
    tx_early_stop <= 1'b0;
    rx_early_stop <= 1'b0;
    stop_error    <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
endmodule // m2pd_periph_model

// *** test/tb_top.sv ***
// Self-checking bench of the DMA channel buffer and status block.
`timescale 1ns/100ps
`include "m2pd_params.svh"

module tb_top;
  logic        pclk, presetn, pclken, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, active_addr, r, a0, a1;
  logic [15:0] n0, n1;
  logic        xfer_active, active_buf, tx_done, rx_done, pack_flush, halt_irq, refill_irq;
  logic        byte_moved, tx_stop, rx_stop, stop_err;
  logic [2:0]  fill;
  int          fails, n_tests, nh, nr, nd, nx;

  m2pd_channel dut (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .byte_moved(byte_moved), .tx_early_stop(tx_stop), .rx_early_stop(rx_stop), .stop_error(stop_err),
    .pack_fill(fill), .xfer_active(xfer_active), .active_buf(active_buf), .active_addr(active_addr),
    .tx_count_done(tx_done), .rx_count_done(rx_done), .pack_flush(pack_flush), .halt_irq(halt_irq),
    .refill_irq(refill_irq));

  m2pd_periph_model u_per (.pclk(pclk), .xfer_active(xfer_active), .byte_moved(byte_moved),
    .tx_early_stop(tx_stop), .rx_early_stop(rx_stop), .stop_error(stop_err), .pack_fill(fill));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    nh += (halt_irq === 1'b1);
    nr += (refill_irq === 1'b1);
    nd += (tx_done === 1'b1);
    nx += (rx_done === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  // Status word from state code, selector and the fill level seen now.
  function automatic logic [31:0] st(input logic [1:0] s, input logic sel);
    return {22'h0, fill, sel, s, 4'h0};
  endfunction

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    end_of_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {fails, n_tests, nh, nr, nd, nx} = '0;
    pclken = 1'b1;
    void'($urandom(57851));
    n0 = 16'($urandom_range(9, 2));
    n1 = 16'($urandom_range(9, 2));
    a0 = $urandom;
    a1 = $urandom;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`M2PD_OFF_STATUS, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(e), 32'h1);
    $display("test reset done");
    apb(1'b1, `M2PD_OFF_CTRL, 32'h07);
    rd(`M2PD_OFF_STATUS, st(2'h1, 1'b0));
    // The clock enable drops in the access cycle, so the write must wait for pready.
    fork
      apb(1'b1, `M2PD_OFF_LIM0, 32'hffff_0000 | 32'(n0));
      begin
        repeat (2) @(posedge pclk);
        pclken <= 1'b0;
        @(posedge pclk);
        pclken <= 1'b1;
      end
    join
    apb(1'b1, `M2PD_OFF_BUFFER0_START_ADDR, a0);
    rd(`M2PD_OFF_STATUS, st(2'h2, 1'b1));
    rd(`M2PD_OFF_LEFT, 32'(n0));
    rd(`M2PD_OFF_LIVE0, a0);
    rd(`M2PD_OFF_LIM0, 32'(n0));
    $display("test start done");
    apb(1'b1, `M2PD_OFF_LIM1, 32'(n1));
    apb(1'b1, `M2PD_OFF_BUFFER1_START_ADDR, a1);
    rd(`M2PD_OFF_STATUS, st(2'h3, 1'b0));
    chk(32'(active_buf), 32'h0);
    u_per.send(int'(n0), 1'b0, 1'b0, 1'b0);
    rd(`M2PD_OFF_STATUS, st(2'h2, 1'b0) | 32'h2);
    chk(32'(active_buf), 32'h1);
    chk(nr, 1);
    chk(nd, 1);
    rd(`M2PD_OFF_LIVE0, a0 + 32'(n0));
    rd(`M2PD_OFF_LEFT, 32'(n1));
    $display("test switch done");
    u_per.send(int'(n1), 1'b0, 1'b0, 1'b0);
    rd(`M2PD_OFF_STATUS, st(2'h1, 1'b0) | 32'h1);
    chk(nh, 1);
    rd(`M2PD_OFF_LIVE1, a1 + 32'(n1));
    rd(`M2PD_OFF_LEFT, 32'h0);
    $display("test stall done");
    apb(1'b1, `M2PD_OFF_BUFFER0_START_ADDR, a0);
    rd(`M2PD_OFF_STATUS, st(2'h2, 1'b1));
    u_per.send(1, 1'b1, 1'b1, 1'b0);
    apb(1'b0, `M2PD_OFF_STATUS, 32'h0);
    chk(r & 32'h8, 32'h8);
    rd(`M2PD_OFF_LEFT, 32'(n0 - 16'h1));
    apb(1'b1, `M2PD_OFF_CTRL, 32'h0);
    rd(`M2PD_OFF_STATUS, st(2'h0, 1'b1));
    chk(32'(pack_flush), 32'h1);
    $display("test fault done");
    apb(1'b1, `M2PD_OFF_CTRL, 32'h2b);
    apb(1'b1, `M2PD_OFF_BUFFER0_START_ADDR, a0);
    apb(1'b1, `M2PD_OFF_BUFFER1_START_ADDR, a1);
    u_per.send(int'(n0), 1'b0, 1'b0, 1'b1);
    chk(nx, 1);
    chk(nd, 2);
    chk(nr, 1);
    apb(1'b1, `M2PD_OFF_BUFFER0_START_ADDR, a0);
    u_per.send(1, 1'b1, 1'b1, 1'b1);
    rd(`M2PD_OFF_STATUS, st(2'h1, 1'b1) | 32'h8);
    chk(nh, 2);
    apb(1'b1, `M2PD_OFF_CTRL, 32'h3b);
    apb(1'b1, `M2PD_OFF_BUFFER1_START_ADDR, a1);
    u_per.send(1, 1'b1, 1'b1, 1'b1);
    rd(`M2PD_OFF_STATUS, st(2'h2, 1'b0) | 32'h8);
    rd(`M2PD_OFF_LEFT, 32'(n1 - 16'h1));
    $display("test rx done");
    end_of_test();
  end
endmodule // tb_top
